// ---- logic/sfw_cfg.svh ----
// Overview of operation
// - burst setting is C0h then enable nibble
// - depth nibble picks 8/16/32/64, 1x disables
// - burst wraps inside aligned unit of page
// - wrap off at reset, kept until changed
// - wrap applies to listed quad/single reads
// - toggling byte after address enters command skip
// - command skip only for listed read opcodes
// - in command skip, frame starts with address
// - toggling continuation byte keeps command skip
// - non-toggling pair leaves command skip, except while a wipe is busy
// - controller reset returns to single line
// - sector wipe clears 4K sector, any address
// - block wipes clear 32K or 64K block
// - opcode, 3-byte address, then select rises
// - wipe refused unless select rises on boundary
// - 8 clocks single line, 2 clocks quad
// - busy during wipe, latch cleared on finish
// - guarded area not wiped, chip needs zeros
// - continuation byte follows the 24-bit address
`ifndef SFW_CFG_SVH
`define SFW_CFG_SVH

// ****************************************
// opcodes
// ****************************************
`define SFW_OP_BURST_CFG 8'hc0
`define SFW_OP_READ_QIO  8'heb
`define SFW_OP_READ_FAST 8'h0b
`define SFW_OP_READ_SHRT 8'he7
`define SFW_OP_SECTOR    8'h20
`define SFW_OP_HALF_BLK  8'h52
`define SFW_OP_BLOCK     8'hd8
`define SFW_OP_CHIP      8'h60
`define SFW_ALL_ONES     8'hff

// ****************************************
// frame lengths in link clocks
// ****************************************
`define SFW_CNT_MAX      6'h3f
`define SFW_LINE0_CLKS   6'h20
`define SFW_NIB_CLKS     6'h10
`define SFW_SPI_OP_END   6'h08
`define SFW_QPI_OP_END   6'h02
`define SFW_SPI_ADR_END  6'h20
`define SFW_QPI_ADR_END  6'h08
`define SFW_SPI_BST_END  6'h10
`define SFW_QPI_BST_END  6'h04
`define SFW_SPI_P_END    6'h10
`define SFW_QPI_P_END    6'h0a
`define SFW_XIP_P_END    6'h08
`define SFW_RESET_CLKS   6'h08

// ****************************************
// fields, sizes, reset values
// ****************************************
`define SFW_WRAP_OFF_BIT 4
`define SFW_WRAP_EN_RST  1'h0
`define SFW_WRAP_D_RST   2'h0
`define SFW_WRAP_BASE    8'h07
`define SFW_SECTOR_MASK  24'h000fff
`define SFW_HALF_MASK    24'h007fff
`define SFW_BLOCK_MASK   24'h00ffff
`define SFW_CHIP_MASK    24'hffffff
`define SFW_GUARD_UNIT   25'h0010000
`define SFW_SPACE_TOP    25'h1000000
`define SFW_GUARD_ALL    4'h9

`endif

// ---- logic/sfw_pkg.sv ----
package sfw_pkg;

  typedef enum logic [1:0] {
    SFW_WIPE_SECTOR,
    SFW_WIPE_HALF,
    SFW_WIPE_BLOCK,
    SFW_WIPE_CHIP
  } sfw_wipe_kind_e;

  typedef struct packed {
    logic       en;
    logic [1:0] depth;
  } sfw_wrap_s;

  typedef struct packed {
    logic           start;
    sfw_wipe_kind_e kind;
    logic [23:0]    base;
  } sfw_wipe_s;

  typedef struct packed {
    logic        valid;
    logic [23:0] start;
    logic [7:0]  mask;
  } sfw_burst_s;

endpackage : sfw_pkg

// ---- logic/sfw_sync2.sv ----
`timescale 1ns/1ps
module sfw_sync2 #(
  parameter int          WIDTH = 1,
  parameter logic        RST_VAL = 1'b0
) (
  input  wire logic             i_clk,
  input  wire logic             i_arst_n,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] held;
  } sfw_sync_s;

  sfw_sync_s st_q;
  sfw_sync_s st_d;

  // first stage feeds only the second stage
  always_comb begin
    st_d      = st_q;
    st_d.meta = i_async;
    st_d.held = st_q.meta;
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_q <= {2{{WIDTH{RST_VAL}}}};
    end else begin
      st_q <= st_d;
    end
  end

  assign o_sync = st_q.held;
endmodule : sfw_sync2

// ---- logic/sfw_flash_seq.sv ----
`timescale 1ns/1ps
`include "sfw_cfg.svh"
module sfw_flash_seq
  import sfw_pkg::*;
#(
  parameter int unsigned TMR_W            = 24,
  parameter int unsigned SECTOR_WIPE_CYC  = 1000,
  parameter int unsigned HALF_WIPE_CYC    = 2000,
  parameter int unsigned BLOCK_WIPE_CYC   = 4000,
  parameter int unsigned FULL_WIPE_CYC    = 20000
) (
  input  wire logic       i_sys_clk,
  input  wire logic       i_arst_n,
  input  wire logic       i_sclk,
  input  wire logic       i_cs_n,
  input  wire logic [3:0] i_quad_lines,
  input  wire logic       i_quad_enter,
  input  wire logic       i_quad_leave,
  input  wire logic       i_wlatch_set,
  input  wire logic [3:0] i_guard_bits,
  output logic            o_busy_flag,
  output logic            o_write_latch_flag,
  output logic            o_quad_cmd_mode,
  output logic            o_xip_active,
  output sfw_wrap_s       o_wrap,
  output sfw_wipe_s       o_wipe,
  output logic            o_wipe_done,
  output logic            o_erase_refused,
  output sfw_burst_s      o_burst
);

  // ****************************************
  // link side: frame capture on the serial clock
  // ****************************************
  typedef struct packed {
    logic [5:0]       cnt;
    logic [31:0]      line0;
    logic [15:0][3:0] nib;
  } sfw_link_s;

  sfw_link_s lnk_q;
  sfw_link_s lnk_d;
  sfw_link_s lnk_base;
  logic      frame_rst_n;
  logic      frame_open_q;

  // the captured frame must outlive select high, so only the open flag is
  // cleared by select; the first clock of a frame starts from an empty frame
  assign frame_rst_n = i_arst_n & ~i_cs_n;

  always_comb begin
    lnk_base = frame_open_q ? lnk_q : '0;
    lnk_d    = lnk_base;
    if (lnk_base.cnt < `SFW_LINE0_CLKS) begin
      lnk_d.line0[5'd31 - lnk_base.cnt[4:0]] = i_quad_lines[0];
    end
    if (lnk_base.cnt < `SFW_NIB_CLKS) begin
      lnk_d.nib[4'd15 - lnk_base.cnt[3:0]] = i_quad_lines;
    end
    if (lnk_base.cnt != `SFW_CNT_MAX) begin
      lnk_d.cnt = lnk_base.cnt + 6'h01;
    end
  end

  always_ff @(posedge i_sclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      lnk_q <= '0;
    end else begin
      lnk_q <= lnk_d;
    end
  end

  always_ff @(posedge i_sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      frame_open_q <= 1'b0;
    end else begin
      frame_open_q <= 1'b1;
    end
  end

  // ****************************************
  // system side: select crossing
  // ****************************************
  logic cs_n_sync;

  // captured frame is stable once select has risen, so only select crosses
  sfw_sync2 #(
    .WIDTH   (1),
    .RST_VAL (1'b1)
  ) u_cs_sync (
    .i_clk    (i_sys_clk),
    .i_arst_n (i_arst_n),
    .i_async  (i_cs_n),
    .o_sync   (cs_n_sync)
  );

  // ****************************************
  // system side: sequencer state
  // ****************************************
  typedef struct packed {
    logic           cs_prev;
    logic           quad;
    logic           xip;
    sfw_wrap_s      wrap;
    logic           wlatch;
    logic           busy;
    logic [TMR_W-1:0] tmr;
    sfw_wipe_s      wipe;
    logic           done;
    logic           refused;
    sfw_burst_s     burst;
  } sfw_seq_s;

  sfw_seq_s st_q;
  sfw_seq_s st_d;

  function automatic logic guarded(input logic [3:0] g, input logic [23:0] top_byte);
    logic [24:0] size;
    logic [24:0] start;
    size    = `SFW_GUARD_UNIT << (g - 4'h1);
    start   = `SFW_SPACE_TOP - size;
    guarded = (g != 4'h0) && ((g >= `SFW_GUARD_ALL) || ({1'b0, top_byte} >= start));
  endfunction : guarded

  function automatic logic [7:0] wrap_mask(input logic [1:0] depth);
    wrap_mask = (`SFW_WRAP_BASE << depth) | `SFW_WRAP_BASE;
  endfunction : wrap_mask

  logic [7:0]     op;
  logic [23:0]    eaddr;
  logic [7:0]     bcfg;
  logic [23:0]    raddr;
  logic [7:0]     pbyte;
  logic [5:0]     p_end;
  logic [5:0]     op_end;
  logic [5:0]     adr_end;
  logic [5:0]     bst_end;
  logic           rd_elig;
  logic           toggling;
  logic           ones_seq;
  logic           is_wipe;
  logic [23:0]    wmask;
  sfw_wipe_kind_e wkind;
  logic           cs_rise;

  assign cs_rise = cs_n_sync & ~st_q.cs_prev;

  // field extraction from the captured frame
  always_comb begin
    op      = st_q.quad ? lnk_q.nib[15:14] : lnk_q.line0[31:24];
    eaddr   = st_q.quad ? lnk_q.nib[13:8] : lnk_q.line0[23:0];
    bcfg    = st_q.quad ? lnk_q.nib[13:12] : lnk_q.line0[23:16];
    op_end  = st_q.quad ? `SFW_QPI_OP_END : `SFW_SPI_OP_END;
    adr_end = st_q.quad ? `SFW_QPI_ADR_END : `SFW_SPI_ADR_END;
    bst_end = st_q.quad ? `SFW_QPI_BST_END : `SFW_SPI_BST_END;
    // eligible reads; dual-line reads never qualify
    if (st_q.quad) begin
      rd_elig = (op == `SFW_OP_READ_QIO) || (op == `SFW_OP_READ_FAST);
    end else begin
      rd_elig = (op == `SFW_OP_READ_QIO) || (op == `SFW_OP_READ_SHRT);
    end
    // continuation byte sits right after the address
    if (st_q.xip) begin
      raddr = lnk_q.nib[15:10];
      pbyte = lnk_q.nib[9:8];
      p_end = `SFW_XIP_P_END;
    end else if (st_q.quad) begin
      raddr = lnk_q.nib[13:8];
      pbyte = lnk_q.nib[7:6];
      p_end = `SFW_QPI_P_END;
    end else begin
      raddr = lnk_q.nib[7:2];
      pbyte = lnk_q.nib[1:0];
      p_end = `SFW_SPI_P_END;
    end
    toggling = (pbyte[7:4] == ~pbyte[3:0]);
    if (st_q.quad) begin
      ones_seq = (lnk_q.cnt == `SFW_RESET_CLKS) && (lnk_q.nib[15:8] == {4{`SFW_ALL_ONES}});
    end else begin
      ones_seq = (lnk_q.cnt == `SFW_RESET_CLKS) && (lnk_q.line0[31:24] == `SFW_ALL_ONES);
    end
    is_wipe = 1'b1;
    case (op)
      `SFW_OP_SECTOR: begin
        wkind = SFW_WIPE_SECTOR;
        wmask = `SFW_SECTOR_MASK;
      end
      `SFW_OP_HALF_BLK: begin
        wkind = SFW_WIPE_HALF;
        wmask = `SFW_HALF_MASK;
      end
      `SFW_OP_BLOCK: begin
        wkind = SFW_WIPE_BLOCK;
        wmask = `SFW_BLOCK_MASK;
      end
      `SFW_OP_CHIP: begin
        wkind = SFW_WIPE_CHIP;
        wmask = `SFW_CHIP_MASK;
      end
      default: begin
        wkind   = SFW_WIPE_SECTOR;
        wmask   = `SFW_SECTOR_MASK;
        is_wipe = 1'b0;
      end
    endcase
  end

  // ****************************************
  // system side: next state
  // ****************************************
  logic             len_ok;
  logic             prot;
  logic [TMR_W-1:0] load;

  always_comb begin
    st_d             = st_q;
    st_d.cs_prev     = cs_n_sync;
    st_d.wipe.start  = 1'b0;
    st_d.done        = 1'b0;
    st_d.refused     = 1'b0;
    st_d.burst.valid = 1'b0;
    // chip wipe carries no address, so it ends after the opcode
    len_ok = (wkind == SFW_WIPE_CHIP) ? (lnk_q.cnt == op_end) : (lnk_q.cnt == adr_end);
    if (wkind == SFW_WIPE_CHIP) begin
      prot = (i_guard_bits != 4'h0);
    end else begin
      prot = guarded(i_guard_bits, eaddr | wmask);
    end
    case (wkind)
      SFW_WIPE_SECTOR: load = TMR_W'(SECTOR_WIPE_CYC - 1);
      SFW_WIPE_HALF:   load = TMR_W'(HALF_WIPE_CYC - 1);
      SFW_WIPE_BLOCK:  load = TMR_W'(BLOCK_WIPE_CYC - 1);
      SFW_WIPE_CHIP:   load = TMR_W'(FULL_WIPE_CYC - 1);
      default:         load = TMR_W'(SECTOR_WIPE_CYC - 1);
    endcase

    if (i_quad_enter) begin
      st_d.quad = 1'b1;
    end else if (i_quad_leave) begin
      st_d.quad = 1'b0;
    end

    // self-timed cycle; the latch drops together with busy
    if (st_q.busy) begin
      if (st_q.tmr == '0) begin
        st_d.busy   = 1'b0;
        st_d.wlatch = 1'b0;
        st_d.done   = 1'b1;
      end else begin
        st_d.tmr = st_q.tmr - TMR_W'(1);
      end
    end

    if (cs_rise) begin
      if (ones_seq) begin
        st_d.xip = 1'b0;
      end else if (st_q.xip || (rd_elig && !is_wipe)) begin
        // reads during a wipe are rejected and leave the mode alone
        if (!st_q.busy && (lnk_q.cnt >= p_end)) begin
          st_d.xip         = toggling;
          st_d.burst.valid = st_q.wrap.en;
          st_d.burst.start = raddr;
          st_d.burst.mask  = wrap_mask(st_q.wrap.depth);
        end
      end else if ((op == `SFW_OP_BURST_CFG) && (lnk_q.cnt >= bst_end)) begin
        st_d.wrap.en    = ~bcfg[`SFW_WRAP_OFF_BIT];
        st_d.wrap.depth = bcfg[1:0];
      end else if (is_wipe && (lnk_q.cnt >= op_end)) begin
        if (!st_q.busy && st_q.wlatch && len_ok && !prot) begin
          st_d.busy       = 1'b1;
          st_d.tmr        = load;
          st_d.wipe.start = 1'b1;
          st_d.wipe.kind  = wkind;
          st_d.wipe.base  = eaddr & ~wmask;
        end else begin
          st_d.refused = 1'b1;
        end
      end
    end

    // a fresh unlock wins over the clear at completion
    if (i_wlatch_set) begin
      st_d.wlatch = 1'b1;
    end
  end

  // controller reset drops quad mode, command skip and wrap
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_q            <= '0;
      st_q.cs_prev    <= 1'b1;
      st_q.wrap.en    <= `SFW_WRAP_EN_RST;
      st_q.wrap.depth <= `SFW_WRAP_D_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign o_busy_flag        = st_q.busy;
  assign o_write_latch_flag = st_q.wlatch;
  assign o_quad_cmd_mode    = st_q.quad;
  assign o_xip_active       = st_q.xip;
  assign o_wrap             = st_q.wrap;
  assign o_wipe             = st_q.wipe;
  assign o_wipe_done        = st_q.done;
  assign o_erase_refused    = st_q.refused;
  assign o_burst            = st_q.burst;

endmodule : sfw_flash_seq

// ---- tb/sfw_host_model.sv ----
`timescale 1ns/1ps
// ****
// host side of the link, 12 ns link clock
// ****
module sfw_host_model (
  output logic       o_sclk,
  output logic       o_cs_n,
  output logic [3:0] o_lines
);
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_lines = 4'ha;
  end
  // msb first; clock idles low between frames
  task automatic send(input logic [31:0] v, input int n, input logic q, input logic hold);
    o_cs_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      #3 o_lines = q ? v[4*i+:4] : {~o_lines[3:1], v[i]};
      #3 o_sclk = 1'b1;
      #6 o_sclk = 1'b0;
    end
    if (!hold) begin
      #3 o_cs_n = 1'b1;
      o_lines = ~o_lines;
      #150;
    end
  endtask : send
endmodule : sfw_host_model

// ---- tb/sfw_flash_seq_checker.sv ----
`timescale 1ns/1ps
module sfw_flash_seq_checker
  import sfw_pkg::*;
#(
  parameter int unsigned SECTOR_WIPE_CYC = 1000,
  parameter int unsigned HALF_WIPE_CYC   = 2000,
  parameter int unsigned BLOCK_WIPE_CYC  = 4000,
  parameter int unsigned FULL_WIPE_CYC   = 20000
) (
  input wire logic       i_sys_clk,
  input wire logic       i_arst_n,
  input wire logic [3:0] i_guard_bits,
  input wire logic       o_busy_flag,
  input wire logic       o_write_latch_flag,
  input wire logic       o_quad_cmd_mode,
  input wire logic       o_xip_active,
  input wire sfw_wrap_s  o_wrap,
  input wire sfw_wipe_s  o_wipe,
  input wire logic       o_wipe_done,
  input wire logic       o_erase_refused,
  input wire sfw_burst_s o_burst
);
  // ****
  // busy length per wipe kind
  // ****
  logic [31:0] cnt_q;
  logic [31:0] cyc;
  logic [23:0] msk;
  always_comb begin
    cyc = o_wipe.kind == SFW_WIPE_SECTOR ? SECTOR_WIPE_CYC : o_wipe.kind == SFW_WIPE_HALF ? HALF_WIPE_CYC :
          o_wipe.kind == SFW_WIPE_BLOCK ? BLOCK_WIPE_CYC : FULL_WIPE_CYC;
    msk = o_wipe.kind == SFW_WIPE_SECTOR ? 24'h000fff : o_wipe.kind == SFW_WIPE_HALF ? 24'h007fff : 24'h00ffff;
  end
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n)
      cnt_q <= 32'h0;
    else
      cnt_q <= o_busy_flag ? cnt_q + 32'h1 : 32'h0;
  end
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_arst_n);
  AST_START: assert property (o_wipe.start |-> o_busy_flag && $past(o_write_latch_flag))
    else $error("wipe start without busy or latch");
  AST_DONE: assert property ($fell(o_busy_flag) |-> o_wipe_done && !o_write_latch_flag)
    else $error("busy fell without done");
  AST_TIME: assert property (o_wipe_done |-> cnt_q + 32'h1 >= cyc && cnt_q <= cyc + 32'h1)
    else $error("wipe length off");
  AST_CHIP: assert property (o_wipe.start && o_wipe.kind == SFW_WIPE_CHIP |-> i_guard_bits == 4'h0)
    else $error("chip wipe while guarded");
  AST_ALIGN: assert property (o_wipe.start && o_wipe.kind != SFW_WIPE_CHIP |-> (o_wipe.base & msk) == 24'h0)
    else $error("wipe base not aligned");
  AST_BURST: assert property (o_burst.valid |-> o_wrap.en && o_burst.mask == (8'h08 << o_wrap.depth) - 8'h01)
    else $error("burst unit wrong");
  AST_REFUSE: assert property (o_erase_refused |-> !o_wipe.start && $stable(o_busy_flag))
    else $error("refused wipe changed state");
  AST_RESET: assert property ($rose(i_arst_n) |-> !o_quad_cmd_mode && !o_xip_active && !o_wrap.en)
    else $error("mode kept over reset");
endmodule : sfw_flash_seq_checker

bind sfw_flash_seq sfw_flash_seq_checker #(
  .SECTOR_WIPE_CYC(SECTOR_WIPE_CYC),
  .HALF_WIPE_CYC(HALF_WIPE_CYC),
  .BLOCK_WIPE_CYC(BLOCK_WIPE_CYC),
  .FULL_WIPE_CYC(FULL_WIPE_CYC)
) i_chk (.i_sys_clk, .i_arst_n, .i_guard_bits, .o_busy_flag, .o_write_latch_flag, .o_quad_cmd_mode,
  .o_xip_active, .o_wrap, .o_wipe, .o_wipe_done, .o_erase_refused, .o_burst);

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
`include "sfw_cfg.svh"
module testbench
  import sfw_pkg::*;
;
  // ****
  // harness
  // ****
  logic       i_sys_clk, i_arst_n, i_quad_enter, i_quad_leave, i_wlatch_set;
  logic [3:0] i_guard_bits, lines;
  logic       sclk, cs_n, busy, latch, quad, xip, done, refused;
  sfw_wrap_s  wrap;
  sfw_wipe_s  wipe, wipe_c;
  sfw_burst_s burst, burst_c;
  int         mismatches = 0, comparisons = 0, n_st = 0, n_rf = 0, n_bu = 0;
  sfw_flash_seq #(.SECTOR_WIPE_CYC(20), .HALF_WIPE_CYC(24), .BLOCK_WIPE_CYC(28), .FULL_WIPE_CYC(32)) i_dut (
    .i_sys_clk, .i_arst_n, .i_sclk(sclk), .i_cs_n(cs_n), .i_quad_lines(lines), .i_quad_enter, .i_quad_leave,
    .i_wlatch_set, .i_guard_bits, .o_busy_flag(busy), .o_write_latch_flag(latch), .o_quad_cmd_mode(quad),
    .o_xip_active(xip), .o_wrap(wrap), .o_wipe(wipe), .o_wipe_done(done), .o_erase_refused(refused),
    .o_burst(burst));
  sfw_host_model i_host (.o_sclk(sclk), .o_cs_n(cs_n), .o_lines(lines));
  initial begin
    i_sys_clk = 1'b0;
    forever #12.5 i_sys_clk = ~i_sys_clk;
  end
  // pulses last one cycle, so they are counted here
  always @(posedge i_sys_clk) begin
    if (wipe.start) begin
      n_st <= n_st + 1;
      wipe_c <= wipe;
    end
    if (burst.valid) begin
      n_bu <= n_bu + 1;
      burst_c <= burst;
    end
    if (refused)
      n_rf <= n_rf + 1;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic pins(input logic e, input logic l, input logic w);
    @(posedge i_sys_clk);
    i_quad_enter <= e;
    i_quad_leave <= l;
    i_wlatch_set <= w;
    @(posedge i_sys_clk);
    {i_quad_enter, i_quad_leave, i_wlatch_set} <= 3'h0;
    repeat (2) @(posedge i_sys_clk);
  endtask : pins
  task automatic fr(input logic [31:0] v, input int n, input logic q, input logic hold);
    i_host.send(v, n, q, hold);
    if (!hold)
      @(negedge i_sys_clk);
  endtask : fr
  task automatic rd(input logic [7:0] op, input logic [23:0] a, input logic [7:0] p, input logic q);
    fr({24'h0, op}, q ? 2 : 8, q, 1'b1);
    fr({a, p}, 8, 1'b1, 1'b0);
  endtask : rd
  task automatic t_wrap;
    logic [7:0] d [5] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h10};
    int b;
    for (int k = 0; k < 5; k++) begin
      fr({16'h0, `SFW_OP_BURST_CFG, d[k]}, 16, 1'b0, 1'b0);
      chk("wrap_en", !d[k][4], wrap.en);
      b = n_bu;
      rd(`SFW_OP_READ_SHRT, 24'h1234c5, 8'h00, 1'b0);
      chk("bursts", b + (k < 4), n_bu);
      chk("start", 24'h1234c5, burst_c.start);
      if (k < 4) chk("depth", d[k][1:0], wrap.depth);
    end
    pins(1'b1, 1'b0, 1'b0);
    fr({16'h0, `SFW_OP_BURST_CFG, 8'h01}, 4, 1'b1, 1'b0);
    rd(`SFW_OP_READ_FAST, 24'h0000f3, 8'hff, 1'b1);
    chk("mask", 8'h0f, burst_c.mask);
    pins(1'b0, 1'b1, 1'b0);
    $display("wrap test done");
  endtask : t_wrap
  task automatic t_xip;
    rd(`SFW_OP_READ_FAST, 24'h000100, 8'ha5, 1'b0);
    chk("xip", 1'b0, xip);
    rd(`SFW_OP_READ_QIO, 24'h000100, 8'ha5, 1'b0);
    chk("xip", 1'b1, xip);
    fr({24'h00abcd, 8'h0f}, 8, 1'b1, 1'b0);
    chk("start", 24'h00abcd, burst_c.start);
    fr({24'h000200, 8'haa}, 8, 1'b1, 1'b0);
    chk("xip", 1'b0, xip);
    rd(`SFW_OP_READ_SHRT, 24'h000100, 8'h5a, 1'b0);
    fr(32'hff, 8, 1'b0, 1'b0);
    chk("xip", 1'b0, xip);
    pins(1'b1, 1'b0, 1'b0);
    rd(`SFW_OP_READ_QIO, 24'h000100, 8'hf0, 1'b1);
    chk("xip", 1'b1, xip);
    @(posedge i_sys_clk);
    i_arst_n <= 1'b0;
    repeat (2) @(posedge i_sys_clk);
    i_arst_n <= 1'b1;
    repeat (3) @(negedge i_sys_clk);
    chk("quad", 1'b0, quad);
    chk("wrap_en", 1'b0, wrap.en);
    $display("skip mode test done");
  endtask : t_xip
  task automatic t_wipe(input logic [3:0] g);
    logic [7:0] op [4] = '{`SFW_OP_SECTOR, `SFW_OP_HALF_BLK, `SFW_OP_BLOCK, `SFW_OP_CHIP};
    int s;
    @(posedge i_sys_clk);
    i_guard_bits <= g;
    for (int k = 0; k < 4; k++) begin
      pins(1'b0, 1'b0, 1'b1);
      s = n_st;
      fr(k < 3 ? {op[k], 24'h007c5b} : {24'h0, op[k]}, k < 3 ? 32 : 8, 1'b0, 1'b0);
      chk("starts", s + (g == 4'h0 || k < 3), n_st);
      chk("kind", (g == 4'h0 || k < 3) ? k : 2, wipe_c.kind);
      for (s = 0; s < 60 && busy; s++) @(negedge i_sys_clk);
      chk("latch", g != 4'h0 && k > 2, latch);
    end
    fr({`SFW_OP_SECTOR, 24'hff1000}, 32, 1'b0, 1'b0);
    chk("busy", 1'b0, busy);
    pins(1'b0, 1'b0, 1'b1);
    s = n_rf;
    fr({24'h0, `SFW_OP_SECTOR}, 8, 1'b0, 1'b1);
    fr(32'h2001, 25, 1'b0, 1'b0);
    chk("refused", s + 1, n_rf);
    chk("latch", 1'b1, latch);
    $display("wipe test done");
  endtask : t_wipe
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test
  initial begin
    #300000;
    mismatches++;
    finish_test();
  end
  initial begin
    {i_arst_n, i_quad_enter, i_quad_leave, i_wlatch_set, i_guard_bits} = 8'h0;
    repeat (2) @(posedge i_sys_clk);
    i_arst_n <= 1'b1;
    repeat (4) @(negedge i_sys_clk);
    chk("busy", 1'b0, busy);
    t_wrap();
    t_xip();
    t_wipe(4'h0);
    t_wipe(4'h1);
    finish_test();
  end
endmodule : testbench
